// ==== hw/adc_antenna_diversity_cca.sv ====
// Functional notes
// - Auto modes measure both antennas in preamble and keep the stronger.
// - Antenna chosen in last reception is reused for next transmit.
// - Auto modes alternate antennas until packet arrival, then stop.
// - Three-bit mode field at bits 7..5 of control register, reset zero.
// - Fixed codes drive set pin levels in and outside receive/transmit.
// - Codes 100/101 run auto selection; idle pins low or high.
// - Codes 110/111 run beacon variant; idle pins low or high.
// - Strength readable as unsigned 8-bit, half decibel per step.
// - Strength readable anytime, refreshed every four bit periods.
// - Writable 8-bit threshold register sets comparison level.
// - After preamble evaluation, strength above threshold sets status bit.
// - Strength status routed to general pin when function code is 1110.
`timescale 1ns/1ps
module adc_antenna_diversity_cca
  import adc_pkg::*;
#(
  parameter int BIT_PERIOD_CYCLES = ADC_BIT_PERIOD_CYCLES,
  parameter int DWELL_BITS        = ADC_DWELL_BITS,
  parameter int BEACON_DWELL_BITS = ADC_BEACON_DWELL_BITS
)(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       rx_active,
  input  wire logic       tx_active,
  input  wire logic       packet_detect,
  input  wire logic [7:0] strength_in,
  output logic            antenna_pin_one,
  output logic            antenna_pin_two,
  output logic            general_pin_function,
  output logic            interrupt_out_n
);
  initial
  begin
    if (DWELL_BITS < 1 || DWELL_BITS > 255 || BEACON_DWELL_BITS < 1 || BEACON_DWELL_BITS > 255)
      $error("Dwell lengths must be 1..255 bit periods");
  end

  initial
  begin
    if (BIT_PERIOD_CYCLES < 2 || BIT_PERIOD_CYCLES > 65536)
      $error("BIT_PERIOD_CYCLES must be 2..65536");
  end

  typedef enum logic [3:0] {
    ADC_ST_IDLE   = 4'b0001,
    ADC_ST_SEARCH = 4'b0010,
    ADC_ST_HOLD   = 4'b0100,
    ADC_ST_TX     = 4'b1000
  } adc_phase_t;

  typedef struct packed {
    adc_phase_t phase;
    logic [7:0] opctl_two;
    logic [7:0] irq_enable;
    logic [7:0] threshold;
    logic [3:0] gpin_func;
    logic       strength_flag;
    logic [7:0] strength;
    logic [7:0] strength_prev;
    logic [7:0] strength_held;
    logic [1:0] refresh_count;
    logic [7:0] dwell_count;
    logic       current_b;
    logic       chosen_b;
    logic [7:0] level_a;
    logic [7:0] level_b;
    logic       seen_a;
    logic       seen_b;
    logic [7:0] rdata;
    logic       pin_one;
    logic       pin_two;
    logic       gpin;
    logic       irq_n;
  } adc_state_t;

  adc_state_t state;
  adc_state_t next_state;

  logic       bit_tick;
  logic [9:0] sync_bus;
  logic       rx_sync;
  logic       tx_sync;
  logic [7:0] strength_sync;

  adc_bit_tick #(
    .PERIOD_CYCLES (BIT_PERIOD_CYCLES)
  ) u_bit_tick (
    .core_clk (core_clk),
    .reset    (reset),
    .tick     (bit_tick)
  );

  // Modem-side levels are treated as asynchronous
  adc_sync2 #(
    .WIDTH (10)
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in ({rx_active, tx_active, strength_in}),
    .sync_out (sync_bus)
  );

  assign rx_sync       = sync_bus[9];
  assign tx_sync       = sync_bus[8];
  assign strength_sync = sync_bus[7:0];

  function automatic logic is_auto(input logic [2:0] mode);
    is_auto = mode[2];
  endfunction

  function automatic logic [7:0] dwell_len(input logic [2:0] mode);
    dwell_len = (mode[1]) ? 8'(BEACON_DWELL_BITS) : 8'(DWELL_BITS);
  endfunction

  logic [2:0] mode;
  logic       irq_clear_hit;
  logic       strength_event;

  always_comb
  begin
    mode = state.opctl_two[ADC_MODE_LSB +: 3];
    next_state = state;
    next_state.rdata = 8'h00;
    strength_event = 1'b0;
    irq_clear_hit = 1'b0;

    // Multi-bit sample is taken only once two cycles agree
    next_state.strength_prev = strength_sync;
    if (strength_sync == state.strength_prev)
      next_state.strength_held = strength_sync;

    // Strength sample refreshed every four bit periods
    if (bit_tick)
    begin
      next_state.refresh_count = state.refresh_count + 2'h1;
      if (state.refresh_count == 2'(ADC_REFRESH_BITS - 1))
        next_state.strength = state.strength_held;
    end

    // Antenna selection sequence
    unique case (state.phase)
      ADC_ST_IDLE:
      begin
        if (rx_sync)
        begin
          next_state.phase = ADC_ST_SEARCH;
          next_state.dwell_count = 8'h00;
          next_state.seen_a = 1'b0;
          next_state.seen_b = 1'b0;
        end
        else if (tx_sync)
        begin
          next_state.phase = ADC_ST_TX;
          next_state.current_b = state.chosen_b;
        end
      end
      ADC_ST_SEARCH:
      begin
        if (!rx_sync)
        begin
          next_state.phase = ADC_ST_IDLE;
          next_state.chosen_b = state.current_b;
        end
        else if (packet_detect)
        begin
          next_state.phase = ADC_ST_HOLD;
          if (is_auto(mode) && state.seen_a && state.seen_b)
            next_state.current_b = (state.level_b > state.level_a);
          if (state.strength > state.threshold)
            strength_event = 1'b1;
        end
        else if (bit_tick && is_auto(mode))
        begin
          if (state.dwell_count == dwell_len(mode) - 8'h01)
          begin
            next_state.dwell_count = 8'h00;
            if (state.current_b)
            begin
              next_state.level_b = state.strength_held;
              next_state.seen_b = 1'b1;
            end
            else
            begin
              next_state.level_a = state.strength_held;
              next_state.seen_a = 1'b1;
            end
            next_state.current_b = !state.current_b;
          end
          else
            next_state.dwell_count = state.dwell_count + 8'h01;
        end
      end
      ADC_ST_HOLD:
      begin
        if (!rx_sync)
        begin
          next_state.phase = ADC_ST_IDLE;
          next_state.chosen_b = state.current_b;
        end
      end
      ADC_ST_TX:
      begin
        next_state.current_b = state.chosen_b;
        if (!tx_sync)
          next_state.phase = ADC_ST_IDLE;
      end
      default:
        next_state.phase = ADC_ST_IDLE;
    endcase

    // Register writes
    if (reg_write)
    begin
      unique case (reg_addr)
        ADC_ADDR_IRQ_ENABLE: next_state.irq_enable = reg_wdata;
        ADC_ADDR_OPCTL_TWO:  next_state.opctl_two = reg_wdata;
        ADC_ADDR_THRESHOLD:  next_state.threshold = reg_wdata;
        ADC_ADDR_GPIN_FUNC:  next_state.gpin_func = reg_wdata[3:0];
        ADC_ADDR_IRQ_CLEAR:  irq_clear_hit = reg_wdata[ADC_STRENGTH_BIT];
        default:             ;
      endcase
    end

    // Sticky flag: a new event wins over a clear
    if (strength_event)
      next_state.strength_flag = 1'b1;
    else if (irq_clear_hit)
      next_state.strength_flag = 1'b0;

    // Register reads, data stand one cycle later
    if (reg_read)
    begin
      unique case (reg_addr)
        ADC_ADDR_IRQ_FLAGS:
          next_state.rdata = 8'(state.strength_flag) << ADC_STRENGTH_BIT;
        ADC_ADDR_IRQ_ENABLE: next_state.rdata = state.irq_enable;
        ADC_ADDR_OPCTL_TWO:  next_state.rdata = state.opctl_two;
        ADC_ADDR_STRENGTH:   next_state.rdata = state.strength;
        ADC_ADDR_THRESHOLD:  next_state.rdata = state.threshold;
        ADC_ADDR_GPIN_FUNC:  next_state.rdata = {4'h0, state.gpin_func};
        default:             next_state.rdata = 8'h00;
      endcase
    end

    // Pin pair drive
    if (rx_sync || tx_sync)
    begin
      if (is_auto(mode))
      begin
        next_state.pin_one = next_state.current_b;
        next_state.pin_two = !next_state.current_b;
      end
      else
      begin
        next_state.pin_one = mode[0];
        next_state.pin_two = !mode[0];
      end
    end
    else
    begin
      next_state.pin_one = (is_auto(mode)) ? mode[0] : mode[1];
      next_state.pin_two = (is_auto(mode)) ? mode[0] : mode[1];
    end

    next_state.gpin = (state.gpin_func == ADC_GPIN_STRENGTH) && state.strength_flag;
    next_state.irq_n = !(state.strength_flag && state.irq_enable[ADC_STRENGTH_BIT]);
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= '0;
      state.phase <= ADC_ST_IDLE;
      state.opctl_two <= ADC_OPCTL_TWO_RST;
      state.irq_enable <= ADC_IRQ_ENABLE_RST;
      state.threshold <= ADC_THRESHOLD_RST;
      state.gpin_func <= ADC_GPIN_FUNC_RST;
      state.irq_n <= 1'b1;
    end
    else
      state <= next_state;
  end

  assign reg_rdata            = state.rdata;
  assign antenna_pin_one      = state.pin_one;
  assign antenna_pin_two      = state.pin_two;
  assign general_pin_function = state.gpin;
  assign interrupt_out_n      = state.irq_n;
endmodule

// ==== hw/adc_bit_tick.sv ====
`timescale 1ns/1ps
module adc_bit_tick
  import adc_pkg::*;
#(
  parameter int PERIOD_CYCLES = ADC_BIT_PERIOD_CYCLES
)(
  input  wire logic core_clk,
  input  wire logic reset,
  output logic      tick
);
  initial
  begin
    if (PERIOD_CYCLES < 2 || PERIOD_CYCLES > 65536)
      $error("PERIOD_CYCLES must be 2..65536");
  end

  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } adc_tick_state_t;

  adc_tick_state_t state;
  adc_tick_state_t next_state;

  // One-cycle enable once per bit period
  always_comb
  begin
    next_state = state;
    next_state.tick = 1'b0;
    if (state.count == 16'(PERIOD_CYCLES - 1))
    begin
      next_state.count = 16'h0000;
      next_state.tick = 1'b1;
    end
    else
      next_state.count = state.count + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  assign tick = state.tick;
endmodule

// ==== hw/adc_pkg.sv ====
package adc_pkg;
  // Register addresses (byte addresses on the plain port)
  localparam logic [7:0] ADC_ADDR_IRQ_FLAGS   = 8'h04;
  localparam logic [7:0] ADC_ADDR_IRQ_ENABLE = 8'h06;
  localparam logic [7:0] ADC_ADDR_OPCTL_TWO  = 8'h08;
  localparam logic [7:0] ADC_ADDR_STRENGTH   = 8'h26;
  localparam logic [7:0] ADC_ADDR_THRESHOLD  = 8'h27;
  localparam logic [7:0] ADC_ADDR_IRQ_CLEAR  = 8'h40;
  localparam logic [7:0] ADC_ADDR_GPIN_FUNC  = 8'h41;

  // Field positions and reset values
  localparam int         ADC_MODE_LSB         = 5;
  localparam int         ADC_STRENGTH_BIT     = 4;
  localparam logic [7:0] ADC_IRQ_ENABLE_RST   = 8'h03;
  localparam logic [7:0] ADC_OPCTL_TWO_RST    = 8'h00;
  localparam logic [7:0] ADC_THRESHOLD_RST    = 8'h00;
  localparam logic [3:0] ADC_GPIN_FUNC_RST    = 4'h0;
  localparam logic [3:0] ADC_GPIN_STRENGTH    = 4'he;

  // Timing: bit period and preamble windows
  localparam int ADC_CLK_HZ            = 40_000_000;
  localparam int ADC_BIT_RATE_HZ       = 10_000;
  localparam int ADC_BIT_PERIOD_CYCLES = ADC_CLK_HZ / ADC_BIT_RATE_HZ;
  localparam int ADC_REFRESH_BITS      = 4;
  localparam int ADC_DWELL_BITS        = 8;
  localparam int ADC_BEACON_DWELL_BITS = 4;

  // Antenna selection mode codes
  typedef enum logic [2:0] {
    ADC_FIX_A_OFF  = 3'h0,
    ADC_FIX_B_OFF  = 3'h1,
    ADC_FIX_A_ON   = 3'h2,
    ADC_FIX_B_ON   = 3'h3,
    ADC_AUTO_LOW   = 3'h4,
    ADC_AUTO_HIGH  = 3'h5,
    ADC_BEACON_LOW = 3'h6,
    ADC_BEACON_HIGH = 3'h7
  } adc_mode_t;
endpackage

// ==== hw/adc_sync2.sv ====
`timescale 1ns/1ps
module adc_sync2 #(
  parameter int WIDTH = 1
)(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  initial
  begin
    if (WIDTH < 1)
      $error("WIDTH must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } adc_sync_state_t;

  adc_sync_state_t state;
  adc_sync_state_t next_state;

  always_comb
  begin
    next_state.first = async_in;
    next_state.second = state.first;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      state <= '0;
    else
      state <= next_state;
  end

  assign sync_out = state.second;
endmodule

// ==== tb/adc_props.sv ====
`timescale 1ns/1ps
module adc_props
  import adc_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  input wire logic       reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic       rx_active,
  input wire logic       tx_active,
  input wire logic       packet_detect,
  input wire logic [7:0] strength_in,
  input wire logic       antenna_pin_one,
  input wire logic       antenna_pin_two,
  input wire logic       general_pin_function,
  input wire logic       interrupt_out_n
);
  // Shadow copies of the writable registers
  logic [7:0] thr_q;
  logic [7:0] en_q;
  logic [2:0] mode_q;
  logic [3:0] func_q;
  logic       lvl;
  logic       act;
  assign lvl = mode_q[2] ? mode_q[0] : mode_q[1];
  assign act = rx_active || tx_active;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      thr_q  <= ADC_THRESHOLD_RST;
      en_q   <= ADC_IRQ_ENABLE_RST;
      mode_q <= ADC_OPCTL_TWO_RST[7:5];
      func_q <= ADC_GPIN_FUNC_RST;
    end
    else if (reg_write)
    begin
      if (reg_addr == ADC_ADDR_THRESHOLD) thr_q <= reg_wdata;
      if (reg_addr == ADC_ADDR_IRQ_ENABLE) en_q <= reg_wdata;
      if (reg_addr == ADC_ADDR_OPCTL_TWO) mode_q <= reg_wdata[7:5];
      if (reg_addr == ADC_ADDR_GPIN_FUNC) func_q <= reg_wdata[3:0];
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  thr_read_a: assert property (reg_read && reg_addr == ADC_ADDR_THRESHOLD
    |=> reg_rdata == $past(thr_q)) else $error("threshold readback");
  mode_read_a: assert property (reg_read && reg_addr == ADC_ADDR_OPCTL_TWO
    |=> reg_rdata[7:5] == $past(mode_q)) else $error("mode readback");
  idle_pins_a: assert property (($stable(mode_q) && !act)[*5]
    |-> antenna_pin_one == lvl && antenna_pin_two == lvl) else $error("idle pins");
  fixed_pins_a: assert property ((!mode_q[2] && $stable(mode_q) && act)[*5]
    |-> antenna_pin_one == mode_q[0] && antenna_pin_two != mode_q[0]) else $error("fixed pins");
  pin_pair_a: assert property (act[*5] |-> antenna_pin_one != antenna_pin_two)
    else $error("pins not paired");
  irq_mask_a: assert property (!interrupt_out_n
    |-> en_q[ADC_STRENGTH_BIT] || $past(en_q[ADC_STRENGTH_BIT])) else $error("masked irq");
  gpin_mask_a: assert property (general_pin_function
    |-> func_q == ADC_GPIN_STRENGTH || $past(func_q) == ADC_GPIN_STRENGTH) else $error("gpin");
  irq_clear_a: assert property (reg_write && reg_addr == ADC_ADDR_IRQ_CLEAR
    && reg_wdata[ADC_STRENGTH_BIT] && !packet_detect |-> ##2 interrupt_out_n)
    else $error("flag not cleared");
  cover property (!interrupt_out_n);
  cover property (general_pin_function);
  cover property (act && antenna_pin_one);
endmodule
bind adc_antenna_diversity_cca adc_props i_adc_props (.core_clk, .reset, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_active, .tx_active, .packet_detect,
  .strength_in, .antenna_pin_one, .antenna_pin_two, .general_pin_function, .interrupt_out_n);

// ==== tb/adc_switch_model.sv ====
`timescale 1ns/1ps
module adc_switch_model
(
  input  wire logic       antenna_pin_one,
  input  wire logic       antenna_pin_two,
  input  wire logic [7:0] level_a,
  input  wire logic [7:0] level_b,
  output logic      [7:0] strength_out
);
  // Pin one high routes antenna B, pin two high antenna A; otherwise no signal
  always_comb
  begin
    case ({antenna_pin_one, antenna_pin_two})
      2'b10:   strength_out = level_b;
      2'b01:   strength_out = level_a;
      default: strength_out = 8'h00;
    endcase
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
  import adc_pkg::*;
;
  logic       core_clk = 1'b0;
  logic       reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic       rx_active = 1'b0;
  logic       tx_active = 1'b0;
  logic       packet_detect = 1'b0;
  logic [7:0] level_a = 8'h00;
  logic [7:0] level_b = 8'h00;
  logic [7:0] strength_in;
  logic [7:0] reg_rdata;
  logic       antenna_pin_one;
  logic       antenna_pin_two;
  logic       general_pin_function;
  logic       interrupt_out_n;
  int         errors = 0;
  int         cmp_count = 0;
  adc_antenna_diversity_cca #(.BIT_PERIOD_CYCLES(4)) i_adc_antenna_diversity_cca (.core_clk,
    .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .rx_active, .tx_active,
    .packet_detect, .strength_in, .antenna_pin_one, .antenna_pin_two, .general_pin_function,
    .interrupt_out_n);
  adc_switch_model i_adc_switch_model (.antenna_pin_one, .antenna_pin_two, .level_a,
    .level_b, .strength_out(strength_in));
  initial forever #12.5 core_clk = ~core_clk;
  task automatic close_out;
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic pins(input logic [1:0] e);
    chk({6'h00, antenna_pin_one, antenna_pin_two}, {6'h00, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task automatic tog(input int c, output int n);
    logic p;
    n = 0;
    p = antenna_pin_one;
    repeat (c)
    begin
      cyc(1);
      n += int'(antenna_pin_one !== p);
      p = antenna_pin_one;
    end
  endtask
  task automatic t_reset;
    rdc(ADC_ADDR_IRQ_ENABLE, ADC_IRQ_ENABLE_RST);
    rdc(ADC_ADDR_OPCTL_TWO, 8'h00);
    rdc(ADC_ADDR_THRESHOLD, 8'h00);
    rdc(8'h50, 8'h00);
    rdc(ADC_ADDR_IRQ_FLAGS, 8'h00);
    wr(ADC_ADDR_THRESHOLD, 8'ha5);
    rdc(ADC_ADDR_THRESHOLD, 8'ha5);
    wr(ADC_ADDR_STRENGTH, 8'h5a);
    rdc(ADC_ADDR_STRENGTH, 8'h00);
  endtask
  task automatic t_fixed;
    logic [2:0] m;
    for (int i = 0; i < 8; i++)
    begin
      m = 3'(i);
      wr(ADC_ADDR_OPCTL_TWO, {m, 5'h00});
      rdc(ADC_ADDR_OPCTL_TWO, {m, 5'h00});
      cyc(6);
      pins(m[2] ? {2{m[0]}} : {2{m[1]}});
      if (!m[2])
      begin
        @(posedge core_clk);
        tx_active <= 1'b1;
        cyc(6);
        pins({m[0], ~m[0]});
        @(posedge core_clk);
        tx_active <= 1'b0;
      end
    end
  endtask
  task automatic t_auto;
    int n;
    wr(ADC_ADDR_THRESHOLD, 8'h10);
    wr(ADC_ADDR_IRQ_ENABLE, 8'h10);
    wr(ADC_ADDR_GPIN_FUNC, 8'h0e);
    wr(ADC_ADDR_OPCTL_TWO, 8'h80);
    @(posedge core_clk);
    level_a <= 8'h20;
    level_b <= 8'h60;
    rx_active <= 1'b1;
    tog(300, n);
    chk(8'(n > 3), 8'h01);
    chk(8'(n < 11), 8'h01);
    @(posedge core_clk);
    packet_detect <= 1'b1;
    @(posedge core_clk);
    packet_detect <= 1'b0;
    cyc(8);
    tog(100, n);
    chk(8'(n), 8'h00);
    pins(2'b10);
    chk({7'h00, interrupt_out_n}, 8'h00);
    chk({7'h00, general_pin_function}, 8'h01);
    rdc(ADC_ADDR_IRQ_FLAGS, 8'h10);
    rdc(ADC_ADDR_STRENGTH, 8'h60);
    @(posedge core_clk);
    rx_active <= 1'b0;
    tx_active <= 1'b1;
    cyc(6);
    pins(2'b10);
    @(posedge core_clk);
    tx_active <= 1'b0;
    wr(ADC_ADDR_IRQ_ENABLE, 8'h00);
    cyc(3);
    chk({7'h00, interrupt_out_n}, 8'h01);
    wr(ADC_ADDR_IRQ_ENABLE, 8'h10);
    cyc(3);
    chk({7'h00, interrupt_out_n}, 8'h00);
    wr(ADC_ADDR_IRQ_CLEAR, 8'h10);
    cyc(3);
    chk({7'h00, interrupt_out_n}, 8'h01);
  endtask
  task automatic t_beacon;
    logic [1:0] s;
    int         n;
    wr(ADC_ADDR_OPCTL_TWO, 8'hc0);
    @(posedge core_clk);
    level_a <= 8'h70;
    level_b <= 8'h10;
    rx_active <= 1'b1;
    tog(128, n);
    chk(8'(n > 5), 8'h01);
    s = {antenna_pin_one, antenna_pin_two};
    n = 0;
    while (n < 40 && antenna_pin_one === s[1])
    begin
      cyc(1);
      n++;
    end
    chk(8'(n < 40), 8'h01);
    s = {antenna_pin_one, antenna_pin_two};
    @(posedge core_clk);
    rx_active <= 1'b0;
    tx_active <= 1'b1;
    cyc(6);
    pins(s);
    rdc(ADC_ADDR_IRQ_FLAGS, 8'h00);
    @(posedge core_clk);
    tx_active <= 1'b0;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    reset <= 1'b0;
    t_reset;
    t_fixed;
    t_auto;
    t_beacon;
    close_out;
  end
  initial
  begin
    #500000;
    errors++;
    close_out;
  end
endmodule
